// ==== rtl/swic_config.sv ====
`timescale 1ns/1ps
module swic_config
    import swic_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    output logic                   reg_rvalid,
    output logic                   reg_unmapped,
    output logic [DIR_W-1:0]       current_sink_select,
    output logic [NUM_WET-1:0]     wet_sel_1ma,
    output logic [NUM_WET-1:0]     wet_sel_2ma,
    output logic [NUM_WET-1:0]     wet_sel_5ma,
    output logic [NUM_WET-1:0]     wet_sel_10ma,
    output logic [NUM_WET-1:0]     wet_sel_15ma
);

    logic [DATA_W-1:0]  current_direction_select;
    logic [DATA_W-1:0]  wetting_current_low_inputs;
    logic [DATA_W-1:0]  next_current_direction_select;
    logic [DATA_W-1:0]  next_wetting_current_low_inputs;
    logic [DATA_W-1:0]  next_reg_rdata;
    logic               next_reg_rvalid;
    logic               next_reg_unmapped;
    logic [DIR_W-1:0]   next_current_sink_select;
    logic [NUM_WET-1:0] next_wet_sel_1ma;
    logic [NUM_WET-1:0] next_wet_sel_2ma;
    logic [NUM_WET-1:0] next_wet_sel_5ma;
    logic [NUM_WET-1:0] next_wet_sel_10ma;
    logic [NUM_WET-1:0] next_wet_sel_15ma;
    logic [CODE_W-1:0]  input_code [NUM_WET];
    logic [NUM_WET-1:0] dec_1ma;
    logic [NUM_WET-1:0] dec_2ma;
    logic [NUM_WET-1:0] dec_5ma;
    logic [NUM_WET-1:0] dec_10ma;
    logic [NUM_WET-1:0] dec_15ma;

    function automatic logic [CODE_W-1:0] field_at(input logic [DATA_W-1:0] word, input int unsigned lsb);
        field_at = word[lsb +: CODE_W];
    endfunction

    function automatic logic is_direction(input logic [ADDR_W-1:0] addr);
        is_direction = (addr == ADDR_DIRECTION);
    endfunction

    function automatic logic is_wet_low(input logic [ADDR_W-1:0] addr);
        is_wet_low = (addr == ADDR_WET_LOW);
    endfunction

    // The reserved upper direction bits are masked on the way in, so they can never hold a one.
    always_comb begin
        next_current_direction_select = current_direction_select;
        if (reg_wr && is_direction(reg_addr)) begin
            next_current_direction_select = reg_wdata & DIRECTION_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            current_direction_select <= RESET_DIRECTION;
        end else begin
            current_direction_select <= next_current_direction_select;
        end
    end

    always_comb begin
        next_wetting_current_low_inputs = wetting_current_low_inputs;
        if (reg_wr && is_wet_low(reg_addr)) begin
            next_wetting_current_low_inputs = reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wetting_current_low_inputs <= RESET_WET_LOW;
        end else begin
            wetting_current_low_inputs <= next_wetting_current_low_inputs;
        end
    end

    // Read answer one cycle after the strobe; an unmapped address answers zero and flags it.
    always_comb begin
        next_reg_rdata    = '0;
        next_reg_rvalid   = reg_rd;
        next_reg_unmapped = 1'h0;
        if (reg_rd && is_direction(reg_addr)) begin
            next_reg_rdata = current_direction_select & DIRECTION_MASK;
        end else if (reg_rd && is_wet_low(reg_addr)) begin
            next_reg_rdata = wetting_current_low_inputs;
        end else if (reg_rd) begin
            next_reg_unmapped = 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata    <= '0;
            reg_rvalid   <= 1'h0;
            reg_unmapped <= 1'h0;
        end else begin
            reg_rdata    <= next_reg_rdata;
            reg_rvalid   <= next_reg_rvalid;
            reg_unmapped <= next_reg_unmapped;
        end
    end

    // Paired inputs share one field, so both inputs of a pair always carry the same current.
    always_comb begin
        input_code[0]  = field_at(wetting_current_low_inputs, LSB_INPUTS0_1);
        input_code[1]  = field_at(wetting_current_low_inputs, LSB_INPUTS0_1);
        input_code[2]  = field_at(wetting_current_low_inputs, LSB_INPUTS2_3);
        input_code[3]  = field_at(wetting_current_low_inputs, LSB_INPUTS2_3);
        input_code[4]  = field_at(wetting_current_low_inputs, LSB_INPUT4);
        input_code[5]  = field_at(wetting_current_low_inputs, LSB_INPUT5);
        input_code[6]  = field_at(wetting_current_low_inputs, LSB_INPUTS6_7);
        input_code[7]  = field_at(wetting_current_low_inputs, LSB_INPUTS6_7);
        input_code[8]  = field_at(wetting_current_low_inputs, LSB_INPUTS8_9);
        input_code[9]  = field_at(wetting_current_low_inputs, LSB_INPUTS8_9);
        input_code[10] = field_at(wetting_current_low_inputs, LSB_INPUT10);
        input_code[11] = field_at(wetting_current_low_inputs, LSB_INPUT11);
    end

    for (genvar i = 0; i < NUM_WET; i++) begin : g_dec
        swic_level_decode u_dec (
            .code     (input_code[i]),
            .sel_1ma  (dec_1ma[i]),
            .sel_2ma  (dec_2ma[i]),
            .sel_5ma  (dec_5ma[i]),
            .sel_10ma (dec_10ma[i]),
            .sel_15ma (dec_15ma[i])
        );
    end

    always_comb begin
        next_current_sink_select = current_direction_select[DIR_W-1:0];
        next_wet_sel_1ma         = dec_1ma;
        next_wet_sel_2ma         = dec_2ma;
        next_wet_sel_5ma         = dec_5ma;
        next_wet_sel_10ma        = dec_10ma;
        next_wet_sel_15ma        = dec_15ma;
    end

    // The analog selects are registered so the current sources never see decoder glitches.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            current_sink_select <= '0;
            wet_sel_1ma         <= '0;
            wet_sel_2ma         <= '0;
            wet_sel_5ma         <= '0;
            wet_sel_10ma        <= '0;
            wet_sel_15ma        <= '0;
        end else begin
            current_sink_select <= next_current_sink_select;
            wet_sel_1ma         <= next_wet_sel_1ma;
            wet_sel_2ma         <= next_wet_sel_2ma;
            wet_sel_5ma         <= next_wet_sel_5ma;
            wet_sel_10ma        <= next_wet_sel_10ma;
            wet_sel_15ma        <= next_wet_sel_15ma;
        end
    end

endmodule

// ==== rtl/swic_level_decode.sv ====
`timescale 1ns/1ps
module swic_level_decode
    import swic_pkg::*;
(
    input  wire logic [CODE_W-1:0] code,
    output logic                   sel_1ma,
    output logic                   sel_2ma,
    output logic                   sel_5ma,
    output logic                   sel_10ma,
    output logic                   sel_15ma
);

    swic_level_t level;

    always_comb begin
        case (code)
            CODE_OFF:  level = SWIC_OFF;
            CODE_1MA:  level = SWIC_1MA;
            CODE_2MA:  level = SWIC_2MA;
            CODE_5MA:  level = SWIC_5MA;
            CODE_10MA: level = SWIC_10MA;
            default:   level = SWIC_15MA;
        endcase
    end

    always_comb begin
        sel_1ma  = (level == SWIC_1MA);
        sel_2ma  = (level == SWIC_2MA);
        sel_5ma  = (level == SWIC_5MA);
        sel_10ma = (level == SWIC_10MA);
        sel_15ma = (level == SWIC_15MA);
    end

endmodule

// ==== rtl/swic_pkg.sv ====
// Overview of operation
// - Inputs 0 to 9 each have a direction bit: 0 sources current, 1 sinks it.
// - Direction register sits at 1Ch, resets to zero, bits 23-10 read zero.
// - Lower-input wetting current register sits at 1Dh, read-write, resets to zero.
// - Code 0 means no current; codes 1 to 4 select 1, 2, 5, 10 mA.
// - Codes 5, 6 and 7 all select the 15 mA setting.
// - Bits 23-21 and 20-18 drive inputs 11, 10; 17-15 inputs 8-9; 14-12 inputs 6-7.
// - Bits 11-9 and 8-6 drive inputs 5, 4; 5-3 inputs 2-3; 2-0 inputs 0-1.
package swic_pkg;

    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned DATA_W   = 24;
    localparam int unsigned DIR_W    = 10;
    localparam int unsigned NUM_WET  = 12;
    localparam int unsigned CODE_W   = 3;

    localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 6'h1C;
    localparam logic [ADDR_W-1:0] ADDR_WET_LOW   = 6'h1D;

    localparam logic [DATA_W-1:0] RESET_DIRECTION = 24'h000000;
    localparam logic [DATA_W-1:0] RESET_WET_LOW   = 24'h000000;
    localparam logic [DATA_W-1:0] DIRECTION_MASK  = 24'h0003FF;

    localparam int unsigned LSB_INPUT11    = 21;
    localparam int unsigned LSB_INPUT10    = 18;
    localparam int unsigned LSB_INPUTS8_9  = 15;
    localparam int unsigned LSB_INPUTS6_7  = 12;
    localparam int unsigned LSB_INPUT5     = 9;
    localparam int unsigned LSB_INPUT4     = 6;
    localparam int unsigned LSB_INPUTS2_3  = 3;
    localparam int unsigned LSB_INPUTS0_1  = 0;

    localparam logic [CODE_W-1:0] CODE_OFF  = 3'h0;
    localparam logic [CODE_W-1:0] CODE_1MA  = 3'h1;
    localparam logic [CODE_W-1:0] CODE_2MA  = 3'h2;
    localparam logic [CODE_W-1:0] CODE_5MA  = 3'h3;
    localparam logic [CODE_W-1:0] CODE_10MA = 3'h4;

    typedef enum {
        SWIC_OFF,
        SWIC_1MA,
        SWIC_2MA,
        SWIC_5MA,
        SWIC_10MA,
        SWIC_15MA
    } swic_level_t;

endpackage

// ==== test/swic_config_asserts.sv ====
`timescale 1ns/1ps
module swic_config_asserts
    import swic_pkg::*;
(
    input wire logic [0:0]         core_clk,
    input wire logic [0:0]         arst_n,
    input wire logic [ADDR_W-1:0]  reg_addr,
    input wire logic [DATA_W-1:0]  reg_wdata,
    input wire logic [0:0]         reg_wr,
    input wire logic [0:0]         reg_rd,
    input wire logic [DATA_W-1:0]  reg_rdata,
    input wire logic [0:0]         reg_rvalid,
    input wire logic [0:0]         reg_unmapped,
    input wire logic [DIR_W-1:0]   current_sink_select,
    input wire logic [NUM_WET-1:0] wet_sel_1ma,
    input wire logic [NUM_WET-1:0] wet_sel_2ma,
    input wire logic [NUM_WET-1:0] wet_sel_5ma,
    input wire logic [NUM_WET-1:0] wet_sel_10ma,
    input wire logic [NUM_WET-1:0] wet_sel_15ma
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_no_stray_answer: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    a_dir_reserved: assert property (reg_rd && reg_addr == ADDR_DIRECTION |=> reg_rdata[23:10] == 14'h0000)
        else $error("reserved direction bits not zero");
    a_wet_mapped: assert property (reg_rd && reg_addr == ADDR_WET_LOW |=> !reg_unmapped)
        else $error("wetting register flagged unmapped");
    // The selection outputs lag the register by one flop, hence two cycles.
    a_dir_output: assert property (reg_wr && reg_addr == ADDR_DIRECTION |-> ##2
        {14'h0000, current_sink_select} == ($past(reg_wdata, 2) & DIRECTION_MASK)) else $error("direction output wrong");
    a_wet_top_level: assert property (reg_wr && reg_addr == ADDR_WET_LOW |-> ##2
        wet_sel_15ma[0] == (($past(reg_wdata, 2) & 24'h000007) > 24'h000004)) else $error("15 mA select wrong");
    a_wet_input11: assert property (reg_wr && reg_addr == ADDR_WET_LOW |-> ##2
        wet_sel_10ma[11] == (($past(reg_wdata, 2) >> 21) == 24'h000004)) else $error("input 11 select wrong");
    a_wet_input10: assert property (reg_wr && reg_addr == ADDR_WET_LOW |-> ##2
        wet_sel_2ma[10] == ((($past(reg_wdata, 2) >> LSB_INPUT10) & 24'h000007) == 24'h000002))
        else $error("input 10 select wrong");
    a_pair_shared: assert property (wet_sel_5ma[8] == wet_sel_5ma[9] && wet_sel_1ma[0] == wet_sel_1ma[1])
        else $error("paired inputs differ");
    cover property (reg_rd && reg_addr == ADDR_DIRECTION);
    cover property (reg_wr && reg_addr == ADDR_WET_LOW);
    cover property (reg_unmapped);
    cover property (wet_sel_15ma != 12'h000);
endmodule

bind swic_config swic_config_asserts u_swic_config_asserts (
    .core_clk            (core_clk),
    .arst_n              (arst_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .reg_rvalid          (reg_rvalid),
    .reg_unmapped        (reg_unmapped),
    .current_sink_select (current_sink_select),
    .wet_sel_1ma         (wet_sel_1ma),
    .wet_sel_2ma         (wet_sel_2ma),
    .wet_sel_5ma         (wet_sel_5ma),
    .wet_sel_10ma        (wet_sel_10ma),
    .wet_sel_15ma        (wet_sel_15ma)
);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import swic_pkg::*;
;
    logic               core_clk = 1'h0;
    logic               arst_n = 1'h0;
    logic [ADDR_W-1:0]  reg_addr = 6'h00;
    logic [DATA_W-1:0]  reg_wdata = 24'h000000;
    logic               reg_wr = 1'h0;
    logic               reg_rd = 1'h0;
    logic [DATA_W-1:0]  reg_rdata;
    logic               reg_rvalid;
    logic               reg_unmapped;
    logic [DIR_W-1:0]   current_sink_select;
    logic [NUM_WET-1:0] wet_sel_1ma;
    logic [NUM_WET-1:0] wet_sel_2ma;
    logic [NUM_WET-1:0] wet_sel_5ma;
    logic [NUM_WET-1:0] wet_sel_10ma;
    logic [NUM_WET-1:0] wet_sel_15ma;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    swic_config u_swic_config (
        .core_clk            (core_clk),
        .arst_n              (arst_n),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .reg_rvalid          (reg_rvalid),
        .reg_unmapped        (reg_unmapped),
        .current_sink_select (current_sink_select),
        .wet_sel_1ma         (wet_sel_1ma),
        .wet_sel_2ma         (wet_sel_2ma),
        .wet_sel_5ma         (wet_sel_5ma),
        .wet_sel_10ma        (wet_sel_10ma),
        .wet_sel_15ma        (wet_sel_15ma)
    );
    always #12.5 core_clk = ~core_clk;
    task chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Ends one edge past the write so the lagging selection outputs have settled.
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge core_clk);
        #1 reg_wr = 1'h0;
        @(posedge core_clk);
        #1;
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic unm);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_rd = 1'h1;
        @(posedge core_clk);
        #1 reg_rd = 1'h0;
        chk("rvalid", reg_rvalid, 24'h000001);
        chk("rdata", reg_rdata, exp);
        chk("unmapped", reg_unmapped, unm);
    endtask
    task lvl(input logic [NUM_WET-1:0] e1, e2, e5, e10, e15);
        chk("1ma", wet_sel_1ma, e1);
        chk("2ma", wet_sel_2ma, e2);
        chk("5ma", wet_sel_5ma, e5);
        chk("10ma", wet_sel_10ma, e10);
        chk("15ma", wet_sel_15ma, e15);
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #10000;
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'h1;
        lvl(12'h000, 12'h000, 12'h000, 12'h000, 12'h000);
        chk("sink", current_sink_select, 24'h000000);
        rd(ADDR_DIRECTION, 24'h000000, 1'h0);
        rd(ADDR_WET_LOW, 24'h000000, 1'h0);
        $display("test reset done");
        wr(ADDR_DIRECTION, 24'hFFFFFF);
        rd(ADDR_DIRECTION, 24'h0003FF, 1'h0);
        chk("sink", current_sink_select, 24'h0003FF);
        wr(ADDR_DIRECTION, 24'hC00155);
        chk("sink", current_sink_select, 24'h000155);
        $display("test direction done");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_WET_LOW, {8{c[2:0]}});
            rd(ADDR_WET_LOW, {8{c[2:0]}}, 1'h0);
            lvl({12{c == 1}}, {12{c == 2}}, {12{c == 3}}, {12{c == 4}}, {12{c > 4}});
        end
        $display("test codes done");
        wr(ADDR_WET_LOW, 24'h29CA53);
        lvl(12'h810, 12'h40C, 12'h303, 12'h0C0, 12'h020);
        wr(6'h1E, 24'h000000);
        rd(6'h1E, 24'h000000, 1'h1);
        rd(ADDR_WET_LOW, 24'h29CA53, 1'h0);
        $display("test fields done");
        @(posedge core_clk);
        #1 arst_n = 1'h0;
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'h1;
        lvl(12'h000, 12'h000, 12'h000, 12'h000, 12'h000);
        chk("sink", current_sink_select, 24'h000000);
        rd(ADDR_DIRECTION, 24'h000000, 1'h0);
        rd(ADDR_WET_LOW, 24'h000000, 1'h0);
        $display("test reset again done");
        stop_test;
    end
endmodule
